// ===== hdl/rbt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbt_map.svh"

module rbt_lane (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               srst,
    // Control pins, enable normalised to active high
    input  wire rbt_pkg::rbt_ctl_s  ctl,
    // Input bus side
    input  wire rbt_pkg::rbt_word_t din,
    input  wire rbt_pkg::rbt_word_t din_float,
    // Output bus side
    output var  rbt_pkg::rbt_word_t dout,
    output var  rbt_pkg::rbt_word_t dout_oe_n,
    // Captured word stream
    output logic                    cap_valid,
    input  wire logic               cap_ready,
    output var  rbt_pkg::rbt_word_t cap_data,
    output logic                    cap_accept
);
    rbt_pkg::rbt_ctl_s  ctl_m_q;
    rbt_pkg::rbt_ctl_s  ctl_s_q;
    rbt_pkg::rbt_ctl_s  ctl_p_q;
    rbt_pkg::rbt_word_t din_m_q;
    rbt_pkg::rbt_word_t din_s_q;
    rbt_pkg::rbt_word_t flt_m_q;
    rbt_pkg::rbt_word_t flt_s_q;
    rbt_pkg::rbt_word_t held_q;
    rbt_pkg::rbt_word_t eff_p_q;
    rbt_pkg::rbt_word_t store_q;
    rbt_pkg::rbt_word_t eff;
    rbt_pkg::rbt_word_t mem_q [2];
    logic [1:0]         pwr_cnt_q;
    logic [1:0]         cnt_q;
    logic               wr_ptr_q;
    logic               rd_ptr_q;
    logic               ready_q;
    logic               le_fall;
    logic               clk_fall;
    logic               push;
    logic               pop;

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    // Two-flop synchronisers for every pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_m_q <= '0;
            ctl_s_q <= '0;
            ctl_p_q <= '0;
        end else begin
            ctl_m_q <= ctl;
            ctl_s_q <= ctl_m_q;
            ctl_p_q <= ctl_s_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            din_m_q <= `RBT_WORD_RST;
            din_s_q <= `RBT_WORD_RST;
            flt_m_q <= `RBT_WORD_RST;
            flt_s_q <= `RBT_WORD_RST;
        end else begin
            din_m_q <= din;
            din_s_q <= din_m_q;
            flt_m_q <= din_float;
            flt_s_q <= flt_m_q;
        end
    end

    // Keeper: a floating lane reads as its last driven level
    always_comb begin
        eff = (flt_s_q & held_q) | (~flt_s_q & din_s_q);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            held_q <= `RBT_WORD_RST;
        end else begin
            held_q <= eff;
        end
    end

    // Edge captures take the level seen one cycle before the edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            eff_p_q <= `RBT_WORD_RST;
        end else begin
            eff_p_q <= eff;
        end
    end

    always_comb begin
        le_fall  = fell(ctl_p_q.latch_en, ctl_s_q.latch_en);
        clk_fall = fell(ctl_p_q.clk_n, ctl_s_q.clk_n);
    end

    // Power-up: outputs stay off until the synchronisers hold real pin levels
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pwr_cnt_q <= `RBT_CNT_ZERO;
        end else if (pwr_cnt_q != `RBT_PWRUP) begin
            pwr_cnt_q <= pwr_cnt_q + `RBT_CNT_ONE;
        end
    end

    always_comb begin
        ready_q = (pwr_cnt_q == `RBT_PWRUP);
    end

    // Storage element
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            store_q <= `RBT_WORD_RST;
        end else if (ctl_s_q.latch_en) begin
            store_q <= eff;
        end else if (le_fall) begin
            store_q <= eff_p_q;
        end else if (clk_fall) begin
            store_q <= eff_p_q;
        end
        // Otherwise hold
    end

    always_comb begin
        dout = store_q;
    end

    // Output enable only gates the drivers, never the storage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dout_oe_n <= `RBT_ALL_OFF;
        end else if (ready_q && ctl_s_q.out_en) begin
            dout_oe_n <= `RBT_ALL_ON;
        end else begin
            dout_oe_n <= `RBT_ALL_OFF;
        end
    end

    // Two-entry buffer of edge-captured words; a full buffer
    // drops the new word since pins cannot be stalled
    always_comb begin
        cap_valid  = (cnt_q != `RBT_CNT_ZERO);
        cap_accept = (cnt_q != `RBT_FIFO_FULL);
        push       = ready_q && !ctl_s_q.latch_en && (le_fall || clk_fall) && cap_accept;
        pop        = cap_valid && cap_ready;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mem_q[0] <= `RBT_WORD_RST;
            mem_q[1] <= `RBT_WORD_RST;
        end else if (push) begin
            mem_q[wr_ptr_q] <= eff_p_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr_q <= `RBT_PTR_ZERO;
            rd_ptr_q <= `RBT_PTR_ZERO;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + `RBT_PTR_STEP;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + `RBT_PTR_STEP;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q <= `RBT_CNT_ZERO;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + `RBT_CNT_ONE;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - `RBT_CNT_ONE;
        end
    end

    always_comb begin
        cap_data = mem_q[rd_ptr_q];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_transp_follow: assert property (
        ctl_s_q.latch_en |=> store_q == $past(eff)
    ) else $error("transparent path did not follow input");

    a_bit_lanes: assert property (
        ctl_s_q.latch_en && (flt_s_q == `RBT_WORD_RST) |=> dout == $past(din_s_q)
    ) else $error("output lanes differ from input lanes");

    a_hold_stable: assert property (
        !ctl_s_q.latch_en && !le_fall && !clk_fall |=> $stable(store_q)
    ) else $error("stored word changed without capture");

    a_clk_capture: assert property (
        !ctl_s_q.latch_en && clk_fall |=> store_q == $past(eff_p_q)
    ) else $error("clock falling edge did not capture");

    a_le_capture: assert property (
        le_fall ##1 !ctl_s_q.latch_en [*2] |-> (store_q == $past(eff_p_q, 2)) || $past(clk_fall)
    ) else $error("latch enable fall did not capture");

    a_oe_drive: assert property (
        ready_q && ctl_s_q.out_en |=> dout_oe_n == `RBT_ALL_ON
    ) else $error("outputs not driven while enabled");

    a_oe_float: assert property (
        !ctl_s_q.out_en |=> dout_oe_n == `RBT_ALL_OFF
    ) else $error("outputs driven while disabled");

    a_hold_drive: assert property (
        (ctl_s_q.out_en && !ctl_s_q.latch_en) [*3] ##0 (ready_q && !le_fall && !clk_fall)
        |=> dout == $past(dout) && dout_oe_n == `RBT_ALL_ON
    ) else $error("held word not driven steadily");

    a_keeper_hold: assert property (
        flt_s_q == `RBT_ALL_OFF |=> eff_p_q == $past(held_q)
    ) else $error("floating input lost its level");

    a_pwrup_float: assert property (
        !ready_q |-> dout_oe_n == `RBT_ALL_OFF
    ) else $error("outputs driven during power-up");

    a_fifo_full: assert property (
        !cap_accept && !cap_ready |=> !cap_accept && $stable(cap_data)
    ) else $error("full buffer changed without drain");

    c_transparent: cover property (ctl_s_q.latch_en && ready_q && ctl_s_q.out_en);
    c_clock_cap: cover property (!ctl_s_q.latch_en && clk_fall && ready_q);
    c_latch_cap: cover property (le_fall && ready_q);
    c_buf_full: cover property (!cap_accept ##1 pop);
endmodule

module rbt_top (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               srst,
    // Forward control, left to right
    input  wire logic               fwd_out_en,
    input  wire logic               fwd_latch_en,
    input  wire logic               fwd_clk_n,
    // Reverse control, right to left
    input  wire logic               rev_out_en_n,
    input  wire logic               rev_latch_en,
    input  wire logic               rev_clk_n,
    // Left bus pins
    input  wire rbt_pkg::rbt_word_t left_bus_bit_i,
    input  wire rbt_pkg::rbt_word_t left_bus_bit_float,
    output var rbt_pkg::rbt_word_t  left_bus_bit_o,
    output var rbt_pkg::rbt_word_t  left_bus_bit_oe_n,
    // Right bus pins
    input  wire rbt_pkg::rbt_word_t right_bus_bit_i,
    input  wire rbt_pkg::rbt_word_t right_bus_bit_float,
    output var rbt_pkg::rbt_word_t  right_bus_bit_o,
    output var rbt_pkg::rbt_word_t  right_bus_bit_oe_n,
    // Forward capture stream
    output logic                    fwd_cap_valid,
    input  wire logic               fwd_cap_ready,
    output var rbt_pkg::rbt_word_t  fwd_cap_data,
    output logic                    fwd_cap_accept,
    // Reverse capture stream
    output logic                    rev_cap_valid,
    input  wire logic               rev_cap_ready,
    output var rbt_pkg::rbt_word_t  rev_cap_data,
    output logic                    rev_cap_accept
);
    rbt_pkg::rbt_ctl_s fwd_ctl;
    rbt_pkg::rbt_ctl_s rev_ctl;

    always_comb begin
        fwd_ctl = '{out_en: fwd_out_en, latch_en: fwd_latch_en, clk_n: fwd_clk_n};
        rev_ctl = '{out_en: ~rev_out_en_n, latch_en: rev_latch_en, clk_n: rev_clk_n};
    end

    rbt_lane u_fwd (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .ctl        (fwd_ctl),
        .din        (left_bus_bit_i),
        .din_float  (left_bus_bit_float),
        .dout       (right_bus_bit_o),
        .dout_oe_n  (right_bus_bit_oe_n),
        .cap_valid  (fwd_cap_valid),
        .cap_ready  (fwd_cap_ready),
        .cap_data   (fwd_cap_data),
        .cap_accept (fwd_cap_accept)
    );

    rbt_lane u_rev (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .ctl        (rev_ctl),
        .din        (right_bus_bit_i),
        .din_float  (right_bus_bit_float),
        .dout       (left_bus_bit_o),
        .dout_oe_n  (left_bus_bit_oe_n),
        .cap_valid  (rev_cap_valid),
        .cap_ready  (rev_cap_ready),
        .cap_data   (rev_cap_data),
        .cap_accept (rev_cap_accept)
    );

    a_rev_oe_pol: assert property (@(posedge clk_sys) disable iff (srst)
        rev_out_en_n [*4] |-> left_bus_bit_oe_n == `RBT_ALL_OFF
    ) else $error("reverse outputs driven with enable high");

    c_rev_drive: cover property (@(posedge clk_sys) disable iff (srst)
        left_bus_bit_oe_n == `RBT_ALL_ON);
endmodule

`default_nettype wire

// ===== hdl/rbt_map.svh
// Overview of operation
// - Data passes unchanged, bit for bit
// - Latch enable high makes path transparent
// - Enable low, steady clock: contents held
// - Clock falling edge captures input bus
// - Latch enable falling edge captures input
// - Forward enable high drives, low floats outputs
// - Reverse mirrors forward, enable active low
// - Held value driven until next capture
// - Floating inputs keep last valid level
`ifndef RBT_MAP_SVH
`define RBT_MAP_SVH
`define RBT_W          18
`define RBT_WORD_RST   18'h00000
`define RBT_ALL_OFF    18'h3FFFF
`define RBT_ALL_ON     18'h00000
`define RBT_PWRUP      2'h3
`define RBT_CNT_ZERO   2'h0
`define RBT_CNT_ONE    2'h1
`define RBT_FIFO_FULL  2'h2
`define RBT_PTR_ZERO   1'h0
`define RBT_PTR_STEP   1'h1
`endif

// ===== hdl/rbt_pkg.sv
`include "rbt_map.svh"
package rbt_pkg;
    typedef logic [`RBT_W-1:0] rbt_word_t;
    typedef struct packed {
        logic out_en;
        logic latch_en;
        logic clk_n;
    } rbt_ctl_s;
endpackage

// ===== dv/rbt_bus_agent.sv
`timescale 1ns/1ps
`default_nettype none
module rbt_bus_agent (
    // Clock
    input  wire logic               clk_sys,
    // Agent drive request
    input  wire logic               drv_en,
    input  wire rbt_pkg::rbt_word_t drv_val,
    // Device side of the pins
    input  wire rbt_pkg::rbt_word_t dev_o,
    input  wire rbt_pkg::rbt_word_t dev_oe_n,
    // Resolved wire
    output var rbt_pkg::rbt_word_t  wire_lvl,
    output var rbt_pkg::rbt_word_t  wire_float
);
    rbt_pkg::rbt_word_t last_q;
    rbt_pkg::rbt_word_t own_t;

    // Agent value is held steady by the bench before every capture edge
    assign own_t      = drv_en ? drv_val : ~last_q;
    // Undriven bits show the inverse of their last level, so a missing keeper shows up
    assign wire_lvl   = (~dev_oe_n & dev_o) | (dev_oe_n & own_t);
    assign wire_float = dev_oe_n & {$bits(rbt_pkg::rbt_word_t){~drv_en}};

    always_ff @(posedge clk_sys) begin
        last_q <= wire_lvl;
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    logic               clk_sys;
    logic               srst;
    logic               oe [2];
    logic               le [2];
    logic               ck [2];
    logic               drv [2];
    logic               rdy [2];
    logic               vld [2];
    logic               acc [2];
    rbt_pkg::rbt_word_t dv [2];
    rbt_pkg::rbt_word_t obs [2];
    rbt_pkg::rbt_word_t oen [2];
    rbt_pkg::rbt_word_t cd [2];
    rbt_pkg::rbt_word_t lvl [2];
    rbt_pkg::rbt_word_t flt [2];
    logic [31:0]        seed;
    int                 n_errors;
    int                 comparisons;
    int                 cyc;

    rbt_top u_rbt_top (.clk_sys(clk_sys), .srst(srst),
        .fwd_out_en(oe[0]), .fwd_latch_en(le[0]), .fwd_clk_n(ck[0]),
        .rev_out_en_n(~oe[1]), .rev_latch_en(le[1]), .rev_clk_n(ck[1]),
        .left_bus_bit_i(lvl[0]), .left_bus_bit_float(flt[0]),
        .left_bus_bit_o(obs[1]), .left_bus_bit_oe_n(oen[1]),
        .right_bus_bit_i(lvl[1]), .right_bus_bit_float(flt[1]),
        .right_bus_bit_o(obs[0]), .right_bus_bit_oe_n(oen[0]),
        .fwd_cap_valid(vld[0]), .fwd_cap_ready(rdy[0]), .fwd_cap_data(cd[0]), .fwd_cap_accept(acc[0]),
        .rev_cap_valid(vld[1]), .rev_cap_ready(rdy[1]), .rev_cap_data(cd[1]), .rev_cap_accept(acc[1]));
    for (genvar g = 0; g < 2; g++) begin : g_agent
        rbt_bus_agent u_rbt_bus_agent (.clk_sys(clk_sys), .drv_en(drv[g]), .drv_val(dv[g]),
            .dev_o(obs[1-g]), .dev_oe_n(oen[1-g]),
            .wire_lvl(lvl[g]), .wire_float(flt[g]));
    end

    function automatic rbt_pkg::rbt_word_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return rbt_pkg::rbt_word_t'(seed);
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Pops one word with a random stall first, the consumer may lag
    task automatic pop(input int d, input rbt_pkg::rbt_word_t exp);
        int k;
        k = 0;
        settle(int'(seed[1:0]));
        while (vld[d] !== 1'b1 && k < 10) begin
            settle(1);
            k++;
        end
        `CHK(cd[d], exp)
        rdy[d] <= 1'b1;
        settle(1);
        rdy[d] <= 1'b0;
        // Let the pop land before the next head word is looked at
        settle(1);
    endtask

    task automatic run_dir(input int d);
        rbt_pkg::rbt_word_t a;
        rbt_pkg::rbt_word_t b;
        rbt_pkg::rbt_word_t c;
        rbt_pkg::rbt_word_t corner [3];
        corner = '{18'h3FFFF, 18'h00000, 18'h2AAAA};
        settle(1);
        oe[1-d] <= 1'b0;
        drv[1-d] <= 1'b0;
        settle(6);
        drv[d] <= 1'b1;
        oe[d] <= 1'b1;
        le[d] <= 1'b1;
        ck[d] <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            a = (k < 3) ? corner[k] : rnd();
            dv[d] <= a;
            ck[d] <= ~ck[d];
            settle(6);
            `CHK(obs[d], a)
            `CHK(oen[d], 18'h00000)
        end
        ck[d] <= 1'b1;
        a = rnd();
        dv[d] <= a;
        settle(3);
        le[d] <= 1'b0;
        settle(3);
        dv[d] <= ~a;
        settle(6);
        `CHK(obs[d], a)
        b = rnd();
        dv[d] <= b;
        settle(3);
        ck[d] <= 1'b0;
        settle(6);
        `CHK(obs[d], b)
        dv[d] <= ~b;
        settle(3);
        ck[d] <= 1'b1;
        settle(6);
        `CHK(obs[d], b)
        oe[d] <= 1'b0;
        settle(6);
        `CHK(oen[d], 18'h3FFFF)
        c = rnd();
        dv[d] <= c;
        settle(3);
        ck[d] <= 1'b0;
        settle(6);
        `CHK(oen[d], 18'h3FFFF)
        `CHK(acc[d], 1'b0)
        oe[d] <= 1'b1;
        settle(6);
        `CHK(obs[d], c)
        // Third word was refused by the full buffer, so only two come out
        pop(d, a);
        pop(d, b);
        settle(2);
        `CHK(vld[d], 1'b0)
        le[d] <= 1'b1;
        a = rnd();
        dv[d] <= a;
        settle(6);
        drv[d] <= 1'b0;
        settle(6);
        `CHK(obs[d], a)
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        seed = 32'h0000003B;
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        srst = 1'b1;
        oe = '{1'b1, 1'b0};
        le = '{1'b1, 1'b1};
        ck = '{1'b1, 1'b1};
        drv = '{1'b1, 1'b0};
        rdy = '{1'b0, 1'b0};
        dv = '{18'h15555, 18'h0AAAA};
        settle(2);
        srst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            settle(1);
            `CHK(oen[0], 18'h3FFFF)
        end
        run_dir(0);
        run_dir(1);
        finish_test();
    end
endmodule
`default_nettype wire
